// >>> common/eivs_pkg.sv
// Types shared by the external interrupt block.
// Assumes the register header sits in the include path.
package eivs_pkg;
    // Sense select encodings
    typedef enum logic [1:0] {
        EIVS_LOW_LEVEL,
        EIVS_ANY_CHANGE,
        EIVS_FALLING,
        EIVS_RISING
    } eivs_sense_type;
    // Vector move sequencer states
    typedef enum logic [1:0] {
        EIVS_IDLE,
        EIVS_ARMED,
        EIVS_HOLD
    } eivs_move_type;
endpackage

// >>> common/eivs_regs.svh
// Register offsets, field positions, reset values and timing counts.
// Assumes inclusion by bare name from package or design files.
`ifndef EIVS_REGS_SVH
`define EIVS_REGS_SVH
// Byte addresses on the APB slave
// Control register sits at word index 0x35; byte address is four times it
`define EIVS_MCU_CONTROL_IDX 12'h035
`define EIVS_MCU_CONTROL_ADDR 12'h0D4
`define EIVS_SENSE_CTRL_ADDR 12'h040
`define EIVS_IRQ_MASK_ADDR 12'h044
`define EIVS_IRQ_FLAGS_ADDR 12'h048
`define EIVS_PC_MASK0_ADDR 12'h04C
`define EIVS_PC_MASK1_ADDR 12'h050
`define EIVS_PC_MASK2_ADDR 12'h054
`define EIVS_PC_MASK3_ADDR 12'h058
`define EIVS_STATUS_ADDR 12'h05C
// Field positions
`define EIVS_ARM_BIT 0
`define EIVS_SEL_BIT 1
`define EIVS_PULLUP_BIT 4
`define EIVS_DEBUG_BIT 7
`define EIVS_EXT_BIT 0
`define EIVS_PC0_BIT 4
// Reset values
`define EIVS_RESET_BYTE 8'h00
// Arm window length in cycles
`define EIVS_ARM_CYCLES 3'h4
`endif

// >>> design/eivs_pc_group.sv
// One pin change group: mask, change detect, pending request.
// Assumes synchronised pin inputs.
`timescale 1ns/1ps
module eivs_pc_group (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] pins,
    input wire logic [7:0] mask,
    input wire logic flag_clear,
    output logic flag
);
    // Previous pin values and pending flag
    typedef struct packed {
        logic [7:0] last;
        logic pend;
    } eivs_pcg_state_type;
    eivs_pcg_state_type state, next_state;
    logic change;
    // Any enabled toggling input sets the flag; set wins over clear
    always_comb begin
        change = |((pins ^ state.last) & mask);
        next_state.last = pins;
        next_state.pend = change | (state.pend & ~flag_clear);
    end
    // Register state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end
    assign flag = state.pend;
endmodule

// >>> design/eivs_sync.sv
// Two flop synchroniser for one asynchronous level.
// Assumes the input may change at any time relative to pclk.
`timescale 1ns/1ps
module eivs_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic async_in,
    output logic sync_out
);
    // Stage pair; only the second stage is read outside
    typedef struct packed {
        logic first;
        logic second;
    } eivs_sync_state_type;
    eivs_sync_state_type state, next_state;
    // Shift the level through both stages
    always_comb begin
        next_state.first = async_in;
        next_state.second = state.first;
    end
    // Register stages
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end
    assign sync_out = state.second;
endmodule

// >>> design/eivs_top.sv
// External interrupt logic with vector table move control and APB slave.
// Assumes a core that gives global enable, handler acknowledges and
// the executing region; pins arrive asynchronously and are synchronised.
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`include "eivs_regs.svh"
// What this block does
// - Block interrupts from arm until after next instruction
// - Unwritten arm releases block after four cycles
// - Blocking leaves global enable flag untouched
// - Lock bits suppress interrupts from other region
// - Placement picks flash zero or boot base
// - Arm bit self clears after four cycles
// - Pins as outputs still raise interrupts
// - Groups one and zero watch inputs 15-0
// - Pin change detection clocked after synchroniser, wake included
// - Low level requests while pin low
// - Edges and low level both need clock via synchroniser
// - Vanished wake level raises no interrupt
// - Dedicated interrupt needs global and mask
// - Sample pin before edge detection
// - Sense select picks level, change, fall, rise
// - Mask bit 7 enables group three
// - Mask bit 6 enables group two
// - Mask bit 5 enables group one
// - Mask bit 4 enables group zero
// - Mask bit 0 enables dedicated interrupt
// - Pending flags set on trigger, clear on ack
// - Dedicated flag reads zero in level mode
module eivs_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_irq_pin,
    input wire logic [30:0] pin_change_inputs,
    input wire logic global_irq_enable,
    input wire logic instr_done,
    input wire logic exec_in_boot,
    input wire logic boot_lock_app_bit,
    input wire logic boot_lock_boot_bit,
    input wire logic [15:0] boot_base_addr,
    input wire logic [4:0] irq_ack,
    output logic [4:0] irq_request,
    output logic irq_blocked,
    output logic [15:0] vector_base,
    output logic wake_request,
    output logic pullup_global_off,
    output logic debug_port_disable
);
    import eivs_pkg::*;

    // All registered state of the block
    typedef struct packed {
        logic debug_off;
        logic pullup_off;
        logic sel;
        logic arm;
        logic [2:0] arm_cnt;
        eivs_move_type move;
        logic [1:0] sense;
        logic [7:0] mask;
        logic [7:0] pcm0;
        logic [7:0] pcm1;
        logic [7:0] pcm2;
        logic [6:0] pcm3;
        logic ext_last;
        logic ext_pend;
        logic [31:0] rdata;
        logic [4:0] req;
        logic [15:0] vbase;
    } eivs_state_type;
    eivs_state_type state, next_state;

    logic ext_sync; // Synchronised dedicated pin
    logic ext_low_sync; // Synchronised pin low; reset means idle high
    logic [30:0] pc_sync; // Synchronised pin change inputs
    logic [3:0] pc_flag; // Pin change pending flags
    logic [3:0] pc_clear; // Clear strobes for pin change flags
    logic wr_en; // Write access phase
    logic rd_en; // Read setup phase; loads data for the access phase
    logic addr_ok; // Address hits a register
    logic ext_trig; // Dedicated pin trigger in current mode
    logic region_block; // Lock bit suppression
    logic [7:0] flags_view; // Flag register as read

    // Synchronise every asynchronous pin before any flag logic
    eivs_sync u_ext_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(~ext_irq_pin),
        .sync_out(ext_low_sync)
    );
    // Inverted path so a reset synchroniser shows an idle high pin
    assign ext_sync = ~ext_low_sync;
    genvar gi;
    generate
        for (gi = 0; gi < 31; gi++) begin : g_pcsync
            eivs_sync u_pc_sync (
                .pclk(pclk),
                .presetn(presetn),
                .async_in(pin_change_inputs[gi]),
                .sync_out(pc_sync[gi])
            );
        end
    endgenerate

    // Pin change groups 0..3; pins set as outputs still feed back
    eivs_pc_group u_pcg0 (
        .pclk(pclk),
        .presetn(presetn),
        .pins(pc_sync[7:0]),
        .mask(state.pcm0),
        .flag_clear(pc_clear[0]),
        .flag(pc_flag[0])
    );
    eivs_pc_group u_pcg1 (
        .pclk(pclk),
        .presetn(presetn),
        .pins(pc_sync[15:8]),
        .mask(state.pcm1),
        .flag_clear(pc_clear[1]),
        .flag(pc_flag[1])
    );
    eivs_pc_group u_pcg2 (
        .pclk(pclk),
        .presetn(presetn),
        .pins(pc_sync[23:16]),
        .mask(state.pcm2),
        .flag_clear(pc_clear[2]),
        .flag(pc_flag[2])
    );
    eivs_pc_group u_pcg3 (
        .pclk(pclk),
        .presetn(presetn),
        .pins({1'b0, pc_sync[30:24]}),
        .mask({1'b0, state.pcm3}),
        .flag_clear(pc_clear[3]),
        .flag(pc_flag[3])
    );

    // Bus decode; slave answers with no wait state
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & ~penable & ~pwrite;
    always_comb begin
        case (paddr)
            `EIVS_MCU_CONTROL_ADDR, `EIVS_SENSE_CTRL_ADDR,
            `EIVS_IRQ_MASK_ADDR, `EIVS_IRQ_FLAGS_ADDR,
            `EIVS_PC_MASK0_ADDR, `EIVS_PC_MASK1_ADDR,
            `EIVS_PC_MASK2_ADDR, `EIVS_PC_MASK3_ADDR,
            `EIVS_STATUS_ADDR: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    // Flag view with dedicated flag hidden in level mode
    assign flags_view = {pc_flag[3], pc_flag[2], pc_flag[1], pc_flag[0],
        3'h0, state.ext_pend & (state.sense != EIVS_LOW_LEVEL)};

    // Dedicated pin trigger from sampled level
    always_comb begin
        case (eivs_sense_type'(state.sense))
            EIVS_LOW_LEVEL: ext_trig = ~ext_sync;
            EIVS_ANY_CHANGE: ext_trig = ext_sync ^ state.ext_last;
            EIVS_FALLING: ext_trig = state.ext_last & ~ext_sync;
            EIVS_RISING: ext_trig = ~state.ext_last & ext_sync;
            default: ext_trig = 1'b0;
        endcase
    end

    // Vectors in boot area and app lock, or the converse
    assign region_block = (state.sel & ~exec_in_boot & boot_lock_app_bit)
        | (~state.sel & exec_in_boot & boot_lock_boot_bit);

    // Clear strobes: handler entry or write of one
    always_comb begin
        pc_clear = irq_ack[4:1];
        if (wr_en && paddr == `EIVS_IRQ_FLAGS_ADDR) begin
            pc_clear = pc_clear | pwdata[7:4];
        end
    end

    // Next state for registers, move sequencer and requests
    always_comb begin
        next_state = state;
        next_state.ext_last = ext_sync;
        // Level mode keeps flag clear; the live level drives the request
        if (state.sense == EIVS_LOW_LEVEL) begin
            next_state.ext_pend = 1'b0;
        end else if (ext_trig) begin
            next_state.ext_pend = 1'b1;
        end else if (irq_ack[0] || (wr_en &&
            paddr == `EIVS_IRQ_FLAGS_ADDR && pwdata[`EIVS_EXT_BIT])) begin
            next_state.ext_pend = 1'b0;
        end
        // Vector move sequencer
        case (state.move)
            EIVS_IDLE: begin
                next_state.arm_cnt = 3'h0;
            end
            EIVS_ARMED: begin
                next_state.arm_cnt = state.arm_cnt + 3'h1;
                if (state.arm_cnt + 3'h1 >= `EIVS_ARM_CYCLES) begin
                    next_state.arm = 1'b0;
                    next_state.move = EIVS_IDLE;
                end
            end
            EIVS_HOLD: begin
                // Keep blocking until the next instruction retires
                if (instr_done) begin
                    next_state.move = EIVS_IDLE;
                end
            end
            default: next_state.move = EIVS_IDLE;
        endcase
        // Register writes
        if (wr_en) begin
            case (paddr)
                `EIVS_MCU_CONTROL_ADDR: begin
                    next_state.debug_off = pwdata[`EIVS_DEBUG_BIT];
                    next_state.pullup_off = pwdata[`EIVS_PULLUP_BIT];
                    if (state.arm && !pwdata[`EIVS_ARM_BIT]) begin
                        next_state.sel = pwdata[`EIVS_SEL_BIT];
                        next_state.arm = 1'b0;
                        next_state.move = EIVS_HOLD;
                    end else if (pwdata[`EIVS_ARM_BIT]) begin
                        next_state.arm = 1'b1;
                        next_state.arm_cnt = 3'h0;
                        next_state.move = EIVS_ARMED;
                    end
                end
                `EIVS_SENSE_CTRL_ADDR: next_state.sense = pwdata[1:0];
                `EIVS_IRQ_MASK_ADDR: next_state.mask = pwdata[7:0];
                `EIVS_PC_MASK0_ADDR: next_state.pcm0 = pwdata[7:0];
                `EIVS_PC_MASK1_ADDR: next_state.pcm1 = pwdata[7:0];
                `EIVS_PC_MASK2_ADDR: next_state.pcm2 = pwdata[7:0];
                `EIVS_PC_MASK3_ADDR: next_state.pcm3 = pwdata[6:0];
                default: ;
            endcase
        end
        // Read data register, loaded at the setup edge so it stands
        // through the access phase
        next_state.rdata = 32'h0;
        if (rd_en) begin
            case (paddr)
                `EIVS_MCU_CONTROL_ADDR: next_state.rdata[7:0] =
                    {state.debug_off, 2'h0, state.pullup_off, 2'h0,
                     state.sel, state.arm};
                `EIVS_SENSE_CTRL_ADDR: next_state.rdata[1:0] = state.sense;
                `EIVS_IRQ_MASK_ADDR: next_state.rdata[7:0] =
                    state.mask & 8'hF1;
                `EIVS_IRQ_FLAGS_ADDR: next_state.rdata[7:0] = flags_view;
                `EIVS_PC_MASK0_ADDR: next_state.rdata[7:0] = state.pcm0;
                `EIVS_PC_MASK1_ADDR: next_state.rdata[7:0] = state.pcm1;
                `EIVS_PC_MASK2_ADDR: next_state.rdata[7:0] = state.pcm2;
                `EIVS_PC_MASK3_ADDR: next_state.rdata[6:0] = state.pcm3;
                `EIVS_STATUS_ADDR: next_state.rdata[4:0] = state.req;
                default: ;
            endcase
        end
        // Requests: enable bit and global flag, gated by blocking;
        // level mode uses the synchronised live level so a vanished
        // wake level gives no request
        next_state.req[0] = state.mask[`EIVS_EXT_BIT] & global_irq_enable
            & (state.sense == EIVS_LOW_LEVEL ? ~ext_sync
               : state.ext_pend);
        next_state.req[4:1] = pc_flag & state.mask[7:4]
            & {4{global_irq_enable}};
        if (irq_blocked) begin
            next_state.req = 5'h0;
        end
        // Vector start address
        next_state.vbase = state.sel ? boot_base_addr : 16'h0000;
    end

    // Block interrupts while armed, holding, or region locked
    assign irq_blocked = (state.move != EIVS_IDLE) | region_block;

    // Register all state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // Outputs
    assign prdata = state.rdata;
    assign pready = psel & penable;
    assign pslverr = psel & penable & ~addr_ok;
    assign irq_request = state.req;
    assign vector_base = state.vbase;
    assign wake_request = ~ext_sync | (|pc_flag);
    assign pullup_global_off = state.pullup_off;
    assign debug_port_disable = state.debug_off;

    // Assertions
    a_arm_selfclear: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(state.arm) |-> ##[1:4] !state.arm)
        else $error("arm bit did not clear in four cycles");
    a_arm_blocks: assert property (@(posedge pclk) disable iff (!presetn)
        state.arm |-> irq_blocked)
        else $error("interrupts not blocked while armed");
    a_sel_guard: assert property (@(posedge pclk) disable iff (!presetn)
        !$past(state.arm) && !$past(wr_en) |-> $stable(state.sel))
        else $error("placement changed without arm");
    a_vector_base: assert property (@(posedge pclk) disable iff (!presetn)
        !$past(state.sel) |-> vector_base == 16'h0000)
        else $error("vector base not zero");
    a_global_gate: assert property (@(posedge pclk) disable iff (!presetn)
        !$past(global_irq_enable) |-> irq_request == 5'h0)
        else $error("request without global enable");
    a_level_flag: assert property (@(posedge pclk) disable iff (!presetn)
        state.sense == EIVS_LOW_LEVEL |-> flags_view[0] == 1'b0)
        else $error("level mode flag not zero");
    a_level_req: assert property (@(posedge pclk) disable iff (!presetn)
        state.sense == EIVS_LOW_LEVEL && state.mask[0] && global_irq_enable
        && !ext_sync && !irq_blocked |=> irq_request[0])
        else $error("low level gave no request");
    a_block_release: assert property (@(posedge pclk) disable iff (!presetn)
        state.move == EIVS_ARMED |-> ##[1:4] state.move != EIVS_ARMED)
        else $error("arm window too long");
    c_move: cover property (@(posedge pclk) disable iff (!presetn)
        state.move == EIVS_HOLD ##[1:4] state.move == EIVS_IDLE);
    c_pc0: cover property (@(posedge pclk) disable iff (!presetn)
        irq_request[1]);
    c_edge: cover property (@(posedge pclk) disable iff (!presetn)
        state.sense == EIVS_FALLING && irq_request[0]);
endmodule

// >>> testbench/eivs_core_model.sv
// Core-side model: retires instructions and enters interrupt handlers.
// Assumes the bench raises step for one cycle per retired instruction.
`timescale 1ns/1ps
module eivs_core_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [4:0] irq_request,
    input wire logic irq_blocked,
    input wire logic global_irq_enable,
    input wire logic ack_en,
    input wire logic step,
    output logic instr_done,
    output logic [4:0] irq_ack
);
    // Lowest numbered pending request wins the handler entry
    logic [4:0] pick;
    assign pick = irq_request & (~irq_request + 5'h01);
    // One retire pulse per step; one ack pulse per handler entry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr_done <= 1'b0;
            irq_ack <= 5'h00;
        end else begin
            instr_done <= step;
            // Handler entered only when enabled and not blocked
            if (ack_en && global_irq_enable && !irq_blocked
                && !(|irq_ack)) begin
                irq_ack <= pick;
            end else begin
                irq_ack <= 5'h00;
            end
        end
    end
endmodule

// >>> testbench/ext_irq_and_vector_select_tb.sv
// Self-checking bench: APB register tasks, pin stimulus, core model.
// Assumes zero-wait APB with read data standing in the access phase.
`timescale 1ns/1ps
`include "eivs_regs.svh"
module ext_irq_and_vector_select_tb;
    import eivs_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic ext_irq_pin, global_irq_enable, instr_done, exec_in_boot;
    logic boot_lock_app_bit, boot_lock_boot_bit, irq_blocked;
    logic wake_request, pullup_global_off, debug_port_disable;
    logic ack_en, step;
    logic [30:0] pin_change_inputs;
    logic [15:0] boot_base_addr, vector_base;
    logic [4:0] irq_ack, irq_request;
    int failures, n_compared;

    eivs_top i_eivs_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_irq_pin(ext_irq_pin),
        .pin_change_inputs(pin_change_inputs),
        .global_irq_enable(global_irq_enable), .instr_done(instr_done),
        .exec_in_boot(exec_in_boot), .boot_lock_app_bit(boot_lock_app_bit),
        .boot_lock_boot_bit(boot_lock_boot_bit),
        .boot_base_addr(boot_base_addr), .irq_ack(irq_ack),
        .irq_request(irq_request), .irq_blocked(irq_blocked),
        .vector_base(vector_base), .wake_request(wake_request),
        .pullup_global_off(pullup_global_off),
        .debug_port_disable(debug_port_disable));
    eivs_core_model i_eivs_core_model (.pclk(pclk), .presetn(presetn),
        .irq_request(irq_request), .irq_blocked(irq_blocked),
        .global_irq_enable(global_irq_enable), .ack_en(ack_en),
        .step(step), .instr_done(instr_done), .irq_ack(irq_ack));

    // 125 MHz clock
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // Counts, verdict and end of run
    task end_of_test;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Compare one value
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            $display("BAD %s exp %h got %h", nm, e, g);
            failures++;
        end
    endtask

    // One APB transfer; holds the request until pready is sampled
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            failures++;
            end_of_test;
        end
        // Response and read data are taken at the completing edge
        q = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Let registered outputs settle before the caller looks
        #1;
    endtask

    task rd(input logic [11:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, e, q);
    endtask

    // Wait a bounded time for a request level, then compare it
    task wreq(input int i, input logic e);
        repeat (8) begin
            @(posedge pclk);
            if (e && irq_request[i] === 1'b1) break;
        end
        #1 chk("irq_request", {31'h0, e}, {31'h0, irq_request[i]});
    endtask

    // Hang guard
    initial begin
        repeat (20000) @(posedge pclk);
        failures++;
        end_of_test;
    end

    // Main sequence
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {global_irq_enable, exec_in_boot, ack_en, step} = '0;
        {boot_lock_app_bit, boot_lock_boot_bit} = '0;
        ext_irq_pin = 1'b1;
        pin_change_inputs = '0;
        boot_base_addr = 16'h1C00;
        failures = 0;
        n_compared = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(`EIVS_MCU_CONTROL_ADDR, 32'h0, "mcu_control");
        rd(`EIVS_SENSE_CTRL_ADDR, 32'h0, "ext_irq_sense_control");
        rd(`EIVS_IRQ_MASK_ADDR, 32'h0, "ext_irq_mask");
        rd(`EIVS_IRQ_FLAGS_ADDR, 32'h0, "ext_irq_flags");
        // Unmapped place is refused
        apb(1'b1, 12'h0F0, 32'hFF);
        chk("pslverr", 32'h1, {31'h0, serr});
        rd(12'h0F0, 32'h0, "unmapped");
        // Placement write without arming is ignored
        apb(1'b1, `EIVS_MCU_CONTROL_ADDR, 32'h02);
        rd(`EIVS_MCU_CONTROL_ADDR, 32'h0, "placement");
        chk("vector_base", 32'h0, {16'h0, vector_base});
        // Arm left alone: block and arm lapse after four cycles
        apb(1'b1, `EIVS_MCU_CONTROL_ADDR, 32'h01);
        chk("irq_blocked", 32'h1, {31'h0, irq_blocked});
        repeat (6) @(posedge pclk);
        #1 chk("irq_blocked", 32'h0, {31'h0, irq_blocked});
        rd(`EIVS_MCU_CONTROL_ADDR, 32'h0, "arm lapse");
        // Arm then move the table to the boot area
        apb(1'b1, `EIVS_MCU_CONTROL_ADDR, 32'h01);
        apb(1'b1, `EIVS_MCU_CONTROL_ADDR, 32'h02);
        rd(`EIVS_MCU_CONTROL_ADDR, 32'h02, "moved");
        chk("vector_base", 32'h1C00, {16'h0, vector_base});
        chk("irq_blocked", 32'h1, {31'h0, irq_blocked});
        @(posedge pclk) step <= 1'b1;
        @(posedge pclk) step <= 1'b0;
        repeat (3) @(posedge pclk);
        #1 chk("irq_blocked", 32'h0, {31'h0, irq_blocked});
        // Lock bit with boot vectors blocks application code
        @(posedge pclk) boot_lock_app_bit <= 1'b1;
        repeat (2) @(posedge pclk);
        #1 chk("irq_blocked", 32'h1, {31'h0, irq_blocked});
        @(posedge pclk) exec_in_boot <= 1'b1;
        boot_lock_boot_bit <= 1'b1;
        repeat (2) @(posedge pclk);
        #1 chk("irq_blocked", 32'h0, {31'h0, irq_blocked});
        @(posedge pclk) boot_lock_app_bit <= 1'b0;
        boot_lock_boot_bit <= 1'b0;
        global_irq_enable <= 1'b1;
        // Pull-up and debug controls reach their pins; arm stays clear
        apb(1'b1, `EIVS_MCU_CONTROL_ADDR, 32'h90);
        chk("pullup_global_off", 32'h1, {31'h0, pullup_global_off});
        chk("debug_port_disable", 32'h1, {31'h0, debug_port_disable});
        apb(1'b1, `EIVS_IRQ_MASK_ADDR, 32'h01);
        // Each edge mode against a fall and a rise
        for (int m = 1; m < 4; m++) begin
            apb(1'b1, `EIVS_SENSE_CTRL_ADDR, m);
            apb(1'b1, `EIVS_IRQ_FLAGS_ADDR, 32'h01);
            @(posedge pclk) ext_irq_pin <= 1'b0;
            wreq(0, m != 3);
            apb(1'b1, `EIVS_IRQ_FLAGS_ADDR, 32'h01);
            wreq(0, 1'b0);
            @(posedge pclk) ext_irq_pin <= 1'b1;
            wreq(0, m != 2);
            if (m != 2) rd(`EIVS_IRQ_FLAGS_ADDR, 32'h01, "flag");
            apb(1'b1, `EIVS_IRQ_FLAGS_ADDR, 32'h01);
        end
        // Handler entry clears the flag; mask off keeps quiet
        apb(1'b1, `EIVS_SENSE_CTRL_ADDR, 32'h01);
        @(posedge pclk) ext_irq_pin <= 1'b0;
        wreq(0, 1'b1);
        @(posedge pclk) ack_en <= 1'b1;
        wreq(0, 1'b0);
        @(posedge pclk) ack_en <= 1'b0;
        apb(1'b1, `EIVS_IRQ_MASK_ADDR, 32'h00);
        @(posedge pclk) ext_irq_pin <= 1'b1;
        wreq(0, 1'b0);
        // Low level keeps requesting; flag reads zero
        apb(1'b1, `EIVS_IRQ_MASK_ADDR, 32'h01);
        apb(1'b1, `EIVS_SENSE_CTRL_ADDR, 32'h00);
        @(posedge pclk) ext_irq_pin <= 1'b0;
        wreq(0, 1'b1);
        chk("wake_request", 32'h1, {31'h0, wake_request});
        rd(`EIVS_IRQ_FLAGS_ADDR, 32'h0, "level flag");
        wreq(0, 1'b1);
        @(posedge pclk) ext_irq_pin <= 1'b1;
        wreq(0, 1'b0);
        // Each pin change group: enabled pin fires, masked pin does not
        for (int g = 0; g < 4; g++) begin
            apb(1'b1, `EIVS_PC_MASK0_ADDR + 12'(4 * g), 32'h01);
            apb(1'b1, `EIVS_IRQ_MASK_ADDR, 32'h10 << g);
            @(posedge pclk) pin_change_inputs[8 * g] <= 1'b1;
            wreq(1 + g, 1'b1);
            rd(`EIVS_IRQ_FLAGS_ADDR, 32'h10 << g, "pc flag");
            apb(1'b1, `EIVS_IRQ_FLAGS_ADDR, 32'hF0);
            @(posedge pclk) pin_change_inputs[8 * g + 1] <= 1'b1;
            wreq(1 + g, 1'b0);
        end
        end_of_test;
    end
endmodule
